//--- src/pcg_loop.sv
// Functional notes
// - Numerator writes refused while enabled in pulse-train mode; old value kept.
// - Denominator writes refused while enabled in pulse-train mode; old value kept.
// - Numerator is 32-bit, accepted from 1 to 2^26-1.
// - Denominator is 32-bit, accepted from 1 to 2^31-1.
// - Motor pulses equal command pulses times numerator over denominator.
// - First-order command smoothing, 10 ms steps, 0 to 1000, zero bypasses.
// - Position gain is 16-bit, rad/s, 0 to 2047, on position error.
// - Feed-forward gain is 16-bit percentage, 0 to 100.
// - Manual tuning uses user gains only; automatic adjustments off.
// - Auto tuning adjusts position gain from measured inertia, ten bandwidth levels; feed-forward gain stays the user value.
// - Pulse inhibit in position mode ignores pulses and stops the motor.
// - Pulse format: 0 quadrature x4, 1 CW/CCW, 2 pulse plus direction.
`include "pcg_map.svh"

module pcg_loop
  import pcg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PCG_SMOOTH_UNIT_MS * `PCG_CLK_KHZ
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pulse pins
  input  wire logic        pulse_a,
  input  wire logic        pulse_b,
  input  wire logic        pulse_inhibit_input,
  // Feedback and inertia estimate
  input  wire logic [31:0] feedback_position,
  input  wire logic [3:0]  inertia_ratio_log2,
  // Loop outputs
  output logic [31:0]      speed_command,
  output logic [31:0]      position_error,
  output logic             auto_tuning_active
);
  logic [15:0]        smooth_q;
  logic [31:0]        num_q;
  logic [31:0]        den_q;
  logic [15:0]        kpp_q;
  logic [15:0]        pfg_q;
  logic [31:0]        ctrl_q;
  logic [15:0]        kpp_eff_q;
  logic [2:0]         pin_s1_q;
  logic [2:0]         pin_s2_q;
  logic [2:0]         pin_s3_q;
  logic [31:0]        tick_cnt_q;
  logic               tick_q;
  logic signed [31:0] cmd_pos_q;
  logic signed [31:0] filt_q;
  logic signed [31:0] filt_prev_q;
  pcg_acc_t           frac_q;
  pcg_acc_t           n_x;
  logic               run;
  logic               inhibit;
  logic               lock;
  pcg_fmt_e           fmt;
  logic               raw_up;
  logic               raw_dn;
  logic               cmd_up;
  logic               cmd_dn;
  logic               mot_up;
  logic               mot_dn;
  logic [9:0]         idx;
  logic               mapped;
  logic               wr_ok;
  logic               wr_acc;
  logic [31:0]        rd_data;
  logic signed [63:0] err_w;
  logic signed [63:0] rate_w;
  logic signed [63:0] sp_w;
  logic signed [31:0] sp_sat;
  logic [19:0]        kpp_auto;

  function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return v >= lo && v <= hi;
  endfunction

  function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
    if (v > 64'sh7fffffff) begin
      return 32'sh7fffffff;
    end else if (v < -64'sh80000000) begin
      return -32'sh80000000;
    end
    return v[31:0];
  endfunction

  assign run     = ctrl_q[`PCG_CTRL_EN] & ctrl_q[`PCG_CTRL_PT];
  assign lock    = run;
  assign inhibit = pin_s2_q[2];
  assign fmt     = pcg_fmt_e'(ctrl_q[`PCG_CTRL_FMT_LO +: 2]);

  // Pin synchronisers; the third stage only feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= {pulse_inhibit_input, pulse_b, pulse_a};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Pulse format decode
  always_comb begin
    raw_up = 1'b0;
    raw_dn = 1'b0;
    unique case (fmt)
      PCG_FMT_QUAD: begin
        if ((pin_s2_q[0] ^ pin_s3_q[0]) != (pin_s2_q[1] ^ pin_s3_q[1])) begin
          raw_up = pin_s2_q[0] ^ pin_s3_q[1];
          raw_dn = ~(pin_s2_q[0] ^ pin_s3_q[1]);
        end
      end
      PCG_FMT_CWCCW: begin
        raw_up = pin_s2_q[0] & ~pin_s3_q[0] & ~(pin_s2_q[1] & ~pin_s3_q[1]);
        raw_dn = pin_s2_q[1] & ~pin_s3_q[1] & ~(pin_s2_q[0] & ~pin_s3_q[0]);
      end
      PCG_FMT_PULSE_DIR: begin
        raw_up = pin_s2_q[0] & ~pin_s3_q[0] & ~pin_s2_q[1];
        raw_dn = pin_s2_q[0] & ~pin_s3_q[0] & pin_s2_q[1];
      end
      default: raw_up = 1'b0;
    endcase
  end

  assign cmd_up = raw_up & run & ~inhibit;
  assign cmd_dn = raw_dn & run & ~inhibit;

  pcg_gear pcg_gear_inst (
    .clk      (pclk),
    .rst_n    (presetn),
    .clear    (~run),
    .cmd_up   (cmd_up),
    .cmd_dn   (cmd_dn),
    .num      (num_q),
    .den      (den_q),
    .motor_up (mot_up),
    .motor_dn (mot_dn)
  );

  // Command position tracks feedback while idle, so enabling never jumps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pos_q <= 32'sh0;
    end else if (!run) begin
      cmd_pos_q <= feedback_position;
    end else if (mot_up) begin
      cmd_pos_q <= cmd_pos_q + 32'sh1;
    end else if (mot_dn) begin
      cmd_pos_q <= cmd_pos_q - 32'sh1;
    end
  end

  // Smoothing sample tick, one per time-constant unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // First-order filter: each tick adds the error, then N units move one count
  assign n_x = pcg_acc_t'({24'h0, smooth_q});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= 32'sh0;
      frac_q <= '0;
    end else if (!run || smooth_q == 16'h0) begin
      filt_q <= cmd_pos_q;
      frac_q <= '0;
    end else if (tick_q) begin
      frac_q <= frac_q + pcg_acc_t'(cmd_pos_q) - pcg_acc_t'(filt_q);
    end else if (frac_q >= n_x) begin
      filt_q <= filt_q + 32'sh1;
      frac_q <= frac_q - n_x;
    end else if (frac_q <= -n_x) begin
      filt_q <= filt_q - 32'sh1;
      frac_q <= frac_q + n_x;
    end
  end

  // Gain selection
  assign kpp_auto = (20'(ctrl_q[`PCG_CTRL_BW_LO +: 4]) * 20'(`PCG_AUTO_KPP_STEP)) >> inertia_ratio_log2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kpp_eff_q          <= `PCG_RST_KPP;
      auto_tuning_active <= 1'b0;
    end else if (ctrl_q[`PCG_CTRL_AUTO]) begin
      kpp_eff_q          <= in_rng(32'(kpp_auto), 32'h0, `PCG_KPP_MAX) ? kpp_auto[15:0] : 16'(`PCG_KPP_MAX);
      auto_tuning_active <= 1'b1;
    end else begin
      kpp_eff_q          <= kpp_q;
      auto_tuning_active <= 1'b0;
    end
  end

  // Speed command from error and command rate
  assign err_w  = 64'(filt_q) - 64'(signed'(feedback_position));
  assign rate_w = 64'(filt_q) - 64'(filt_prev_q);
  assign sp_w   = 64'(signed'({1'b0, kpp_eff_q})) * err_w
                + ((64'(signed'({1'b0, pfg_q})) * rate_w * `PCG_PCT_MUL) >>> `PCG_PCT_SHIFT);
  assign sp_sat = sat32(sp_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev_q   <= 32'sh0;
      speed_command <= 32'h0;
    end else if (!run || inhibit) begin
      filt_prev_q   <= filt_q;
      speed_command <= 32'h0;
    end else if (tick_q) begin
      filt_prev_q   <= filt_q;
      speed_command <= sp_sat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_error <= 32'h0;
    end else begin
      position_error <= sat32(err_w);
    end
  end

  // APB decode
  assign idx    = paddr[11:2];
  assign mapped = paddr[1:0] == 2'b00 && (idx == `PCG_IDX_SMOOTH || idx == `PCG_IDX_NUM ||
                  idx == `PCG_IDX_DEN || idx == `PCG_IDX_KPP || idx == `PCG_IDX_PFG ||
                  idx == `PCG_IDX_CTRL || idx == `PCG_IDX_STAT || idx == `PCG_IDX_PERR ||
                  idx == `PCG_IDX_SPEED);

  always_comb begin
    wr_ok = 1'b0;
    unique case (idx)
      `PCG_IDX_SMOOTH: wr_ok = in_rng(pwdata, 32'h0, `PCG_SMOOTH_MAX);
      `PCG_IDX_NUM:    wr_ok = !lock && in_rng(pwdata, 32'h1, `PCG_NUM_MAX);
      `PCG_IDX_DEN:    wr_ok = !lock && in_rng(pwdata, 32'h1, `PCG_DEN_MAX);
      `PCG_IDX_KPP:    wr_ok = in_rng(pwdata, 32'h0, `PCG_KPP_MAX);
      `PCG_IDX_PFG:    wr_ok = in_rng(pwdata, 32'h0, `PCG_PFG_MAX);
      `PCG_IDX_CTRL:   wr_ok = pwdata[`PCG_CTRL_FMT_LO +: 2] != 2'b11 &&
                               in_rng(32'(pwdata[`PCG_CTRL_BW_LO +: 4]), 32'h1, `PCG_BW_MAX);
      default:         wr_ok = 1'b0;
    endcase
    wr_ok = wr_ok && mapped;
  end

  assign wr_acc = psel && penable && pready && pwrite;

  always_comb begin
    rd_data = 32'h0;
    unique case (idx)
      `PCG_IDX_SMOOTH: rd_data = {16'h0, smooth_q};
      `PCG_IDX_NUM:    rd_data = num_q;
      `PCG_IDX_DEN:    rd_data = den_q;
      `PCG_IDX_KPP:    rd_data = {16'h0, kpp_q};
      `PCG_IDX_PFG:    rd_data = {16'h0, pfg_q};
      `PCG_IDX_CTRL:   rd_data = ctrl_q;
      `PCG_IDX_STAT:   rd_data = {5'h0, kpp_eff_q[10:0], 13'h0, run, auto_tuning_active, inhibit};
      `PCG_IDX_PERR:   rd_data = position_error;
      `PCG_IDX_SPEED:  rd_data = speed_command;
      default:         rd_data = 32'h0;
    endcase
  end

  // Answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || (pwrite && !wr_ok));
      prdata  <= (psel && !penable && !pwrite && mapped) ? rd_data : 32'h0;
    end
  end

  // Settings; refused writes keep the held value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smooth_q <= `PCG_RST_SMOOTH;
      num_q    <= `PCG_RST_NUM;
      den_q    <= `PCG_RST_DEN;
      kpp_q    <= `PCG_RST_KPP;
      pfg_q    <= `PCG_RST_PFG;
      ctrl_q   <= `PCG_RST_CTRL;
    end else if (wr_acc && wr_ok) begin
      unique case (idx)
        `PCG_IDX_SMOOTH: smooth_q <= pwdata[15:0];
        `PCG_IDX_NUM:    num_q    <= pwdata;
        `PCG_IDX_DEN:    den_q    <= pwdata;
        `PCG_IDX_KPP:    kpp_q    <= pwdata[15:0];
        `PCG_IDX_PFG:    pfg_q    <= pwdata[15:0];
        `PCG_IDX_CTRL:   ctrl_q   <= pwdata & 32'h00000f1f;
        default:         ctrl_q   <= ctrl_q;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_num_lock;
    (wr_acc && idx == `PCG_IDX_NUM && lock) |=> $stable(num_q);
  endproperty
  a_num_lock: assert property (p_num_lock) else $error("numerator changed while locked");
  property p_den_lock;
    (wr_acc && idx == `PCG_IDX_DEN && lock) |=> $stable(den_q);
  endproperty
  a_den_lock: assert property (p_den_lock) else $error("denominator changed while locked");
  property p_num_range;
    num_q >= 32'h1 && num_q <= `PCG_NUM_MAX;
  endproperty
  a_num_range: assert property (p_num_range) else $error("numerator out of range");
  property p_den_range;
    den_q >= 32'h1 && den_q <= `PCG_DEN_MAX;
  endproperty
  a_den_range: assert property (p_den_range) else $error("denominator out of range");
  property p_bypass;
    (run && smooth_q == 16'h0) |=> filt_q == $past(cmd_pos_q);
  endproperty
  a_bypass: assert property (p_bypass) else $error("smoothing not bypassed");
  property p_gain_range;
    kpp_q <= 16'(`PCG_KPP_MAX) && kpp_eff_q <= 16'(`PCG_KPP_MAX);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("position gain out of range");
  property p_ff_range;
    pfg_q <= 16'(`PCG_PFG_MAX);
  endproperty
  a_ff_range: assert property (p_ff_range) else $error("feed-forward out of range");
  property p_manual;
    !ctrl_q[`PCG_CTRL_AUTO] |=> kpp_eff_q == $past(kpp_q) && !auto_tuning_active;
  endproperty
  a_manual: assert property (p_manual) else $error("manual mode not using user gain");
  property p_inhibit;
    (run && inhibit) |-> !cmd_up && !cmd_dn ##1 speed_command == 32'h0;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit did not stop command");
  property p_fmt_legal;
    ctrl_q[`PCG_CTRL_FMT_LO +: 2] != 2'b11 && !(raw_up && raw_dn);
  endproperty
  a_fmt_legal: assert property (p_fmt_legal) else $error("illegal pulse format state");
  property p_speed;
    (tick_q && run && !inhibit) |=> speed_command == $past(sp_sat);
  endproperty
  a_speed: assert property (p_speed) else $error("speed command not updated at tick");
endmodule // pcg_loop

//--- src/pcg_map.svh
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// Register indices; byte address is four times the index
`define PCG_IDX_SMOOTH     10'h110
`define PCG_IDX_NUM        10'h158
`define PCG_IDX_DEN        10'h15a
`define PCG_IDX_KPP        10'h200
`define PCG_IDX_PFG        10'h204
`define PCG_IDX_CTRL       10'h300
`define PCG_IDX_STAT       10'h301
`define PCG_IDX_PERR       10'h302
`define PCG_IDX_SPEED      10'h303

// Reset values
`define PCG_RST_SMOOTH     16'h0
`define PCG_RST_NUM        32'h10
`define PCG_RST_DEN        32'ha
`define PCG_RST_KPP        16'h23
`define PCG_RST_PFG        16'h32
`define PCG_RST_CTRL       32'h0000010a

// Accepted ranges
`define PCG_NUM_MAX        32'h03ffffff
`define PCG_DEN_MAX        32'h7fffffff
`define PCG_SMOOTH_MAX     32'h3e8
`define PCG_KPP_MAX        32'h7ff
`define PCG_PFG_MAX        32'h64
`define PCG_BW_MAX         32'ha

// Control fields
`define PCG_CTRL_EN        0
`define PCG_CTRL_PT        1
`define PCG_CTRL_FMT_LO    2
`define PCG_CTRL_AUTO      4
`define PCG_CTRL_BW_LO     8

// Timing and scaling
`define PCG_CLK_KHZ        40000
`define PCG_SMOOTH_UNIT_MS 10
`define PCG_PCT_MUL        64'sd1311
`define PCG_PCT_SHIFT      17
`define PCG_AUTO_KPP_STEP  16'h000c

`endif

//--- src/pcg_pkg.sv
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_FMT_QUAD,
    PCG_FMT_CWCCW,
    PCG_FMT_PULSE_DIR
  } pcg_fmt_e;
  typedef logic signed [39:0] pcg_acc_t;
endpackage : pcg_pkg

//--- src/pcg_gear.sv
module pcg_gear
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Command side
  input  wire logic        clear,
  input  wire logic        cmd_up,
  input  wire logic        cmd_dn,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  // Motor side
  output logic             motor_up,
  output logic             motor_dn
);
  pcg_acc_t rem_q;
  pcg_acc_t rem_add;
  pcg_acc_t den_x;
  pcg_acc_t num_x;

  assign den_x = pcg_acc_t'({8'h00, den});
  assign num_x = pcg_acc_t'({8'h00, num});

  always_comb begin
    rem_add = rem_q;
    if (cmd_up) begin
      rem_add = rem_q + num_x;
    end else if (cmd_dn) begin
      rem_add = rem_q - num_x;
    end
  end

  // One motor pulse per cycle; the remainder carries the rest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q    <= '0;
      motor_up <= 1'b0;
      motor_dn <= 1'b0;
    end else if (clear) begin
      rem_q    <= '0;
      motor_up <= 1'b0;
      motor_dn <= 1'b0;
    end else if (rem_add >= den_x) begin
      rem_q    <= rem_add - den_x;
      motor_up <= 1'b1;
      motor_dn <= 1'b0;
    end else if (rem_add <= -den_x) begin
      rem_q    <= rem_add + den_x;
      motor_up <= 1'b0;
      motor_dn <= 1'b1;
    end else begin
      rem_q    <= rem_add;
      motor_up <= 1'b0;
      motor_dn <= 1'b0;
    end
  end

  property p_gear_step;
    @(posedge clk) disable iff (!rst_n)
    (!clear && !cmd_up && !cmd_dn && rem_q >= den_x) |=> motor_up && !motor_dn;
  endproperty
  a_gear_step: assert property (p_gear_step) else $error("gear pulse missing");

  property p_rem_carry;
    @(posedge clk) disable iff (!rst_n)
    (!clear && !cmd_up && !cmd_dn && rem_q < den_x && rem_q > -den_x)
      |=> rem_q == $past(rem_q) && !motor_up && !motor_dn;
  endproperty
  a_rem_carry: assert property (p_rem_carry) else $error("gear remainder lost");
endmodule // pcg_gear

//--- dv/pcg_pulse_src.sv
module pcg_pulse_src (
  // Clock
  input  wire logic pclk,
  // Command pulse pins
  output logic      pulse_a,
  output logic      pulse_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end

  // Each event spaced at least four clocks apart
  task automatic send(input logic [1:0] fmt, input logic up, input int n);
    repeat (n) begin
      @(posedge pclk);
      case (fmt)
        2'd0: begin
          if ((pulse_a == pulse_b) == up) pulse_a <= ~pulse_a;
          else pulse_b <= ~pulse_b;
        end
        2'd1: begin
          if (up) pulse_a <= 1'b1;
          else pulse_b <= 1'b1;
          repeat (4) @(posedge pclk);
          pulse_a <= 1'b0;
          pulse_b <= 1'b0;
        end
        default: begin
          pulse_b <= ~up;
          repeat (4) @(posedge pclk);
          pulse_a <= 1'b1;
          repeat (4) @(posedge pclk);
          pulse_a <= 1'b0;
        end
      endcase
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule // pcg_pulse_src

//--- dv/test_position_command_gear_loop.sv
`include "pcg_map.svh"

module test_position_command_gear_loop;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pulse_a;
  logic        pulse_b;
  logic        inhibit;
  logic [31:0] feedback;
  logic [3:0]  inertia;
  logic [31:0] speed_command;
  logic [31:0] position_error;
  logic        auto_on;
  int          err_count;
  int          tests_run;
  int          cyc;

  pcg_loop #(.TICK_CYCLES(100)) pcg_loop_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_a(pulse_a), .pulse_b(pulse_b), .pulse_inhibit_input(inhibit),
    .feedback_position(feedback), .inertia_ratio_log2(inertia),
    .speed_command(speed_command), .position_error(position_error), .auto_tuning_active(auto_on)
  );

  pcg_pulse_src pcg_pulse_src_inst (.pclk(pclk), .pulse_a(pulse_a), .pulse_b(pulse_b));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, i, 32'h0, r, e);
    chk("prdata", x, r);
  endtask

  task automatic t_reset();
    rd(`PCG_IDX_SMOOTH, 32'h0);
    rd(`PCG_IDX_NUM, 32'h10);
    rd(`PCG_IDX_DEN, 32'ha);
    rd(`PCG_IDX_KPP, 32'h23);
    rd(`PCG_IDX_PFG, 32'h32);
    rd(`PCG_IDX_CTRL, `PCG_RST_CTRL);
  endtask

  task automatic t_ranges();
    wr(`PCG_IDX_NUM, 32'h0, 1'b1);
    wr(`PCG_IDX_NUM, 32'h04000000, 1'b1);
    wr(`PCG_IDX_NUM, 32'h03ffffff, 1'b0);
    rd(`PCG_IDX_NUM, 32'h03ffffff);
    wr(`PCG_IDX_DEN, 32'h80000000, 1'b1);
    wr(`PCG_IDX_DEN, 32'h7fffffff, 1'b0);
    wr(`PCG_IDX_KPP, 32'h800, 1'b1);
    wr(`PCG_IDX_KPP, 32'h7ff, 1'b0);
    wr(`PCG_IDX_PFG, 32'h65, 1'b1);
    wr(`PCG_IDX_PFG, 32'h64, 1'b0);
    wr(`PCG_IDX_SMOOTH, 32'h3e9, 1'b1);
    wr(`PCG_IDX_SMOOTH, 32'h3e8, 1'b0);
    rd(`PCG_IDX_SMOOTH, 32'h3e8);
    wr(`PCG_IDX_SMOOTH, 32'h0, 1'b0);
    wr(10'h3ff, 32'h1, 1'b1);
    wr(`PCG_IDX_STAT, 32'h1, 1'b1);
    wr(`PCG_IDX_CTRL, 32'h10f, 1'b1);
  endtask

  task automatic t_gear();
    wr(`PCG_IDX_NUM, 32'h1, 1'b0);
    wr(`PCG_IDX_DEN, 32'h2, 1'b0);
    wr(`PCG_IDX_CTRL, 32'h10b, 1'b0);
    wr(`PCG_IDX_NUM, 32'h5, 1'b1);
    rd(`PCG_IDX_NUM, 32'h1);
    wr(`PCG_IDX_DEN, 32'h3, 1'b1);
    rd(`PCG_IDX_DEN, 32'h2);
    pcg_pulse_src_inst.send(2'd2, 1'b1, 3);
    repeat (20) @(posedge pclk);
    chk("position_error", 32'd1, position_error);
    pcg_pulse_src_inst.send(2'd2, 1'b1, 3);
    repeat (20) @(posedge pclk);
    chk("position_error", 32'd3, position_error);
    wr(`PCG_IDX_CTRL, 32'h107, 1'b0);
    pcg_pulse_src_inst.send(2'd1, 1'b0, 4);
    repeat (20) @(posedge pclk);
    chk("position_error", 32'd1, position_error);
    wr(`PCG_IDX_CTRL, 32'h103, 1'b0);
    pcg_pulse_src_inst.send(2'd0, 1'b1, 8);
    repeat (20) @(posedge pclk);
    chk("position_error", 32'd5, position_error);
    wr(`PCG_IDX_CTRL, 32'h102, 1'b0);
    wr(`PCG_IDX_NUM, 32'h5, 1'b0);
    wr(`PCG_IDX_DEN, 32'h1, 1'b0);
    wr(`PCG_IDX_CTRL, 32'h103, 1'b0);
    pcg_pulse_src_inst.send(2'd0, 1'b1, 1);
    repeat (20) @(posedge pclk);
    chk("position_error", 32'd5, position_error);
  endtask

  task automatic t_speed();
    wr(`PCG_IDX_PFG, 32'h0, 1'b0);
    wr(`PCG_IDX_KPP, 32'h64, 1'b0);
    feedback <= 32'd2;
    repeat (250) @(posedge pclk);
    chk("position_error", 32'd3, position_error);
    chk("speed_command", 32'd300, speed_command);
    rd(`PCG_IDX_SPEED, 32'd300);
  endtask

  task automatic t_inhibit();
    inhibit <= 1'b1;
    repeat (250) @(posedge pclk);
    chk("speed_command", 32'd0, speed_command);
    pcg_pulse_src_inst.send(2'd0, 1'b1, 4);
    repeat (20) @(posedge pclk);
    chk("position_error", 32'd3, position_error);
    inhibit <= 1'b0;
  endtask

  task automatic t_auto();
    logic [31:0] r;
    logic        e;
    inertia <= 4'd2;
    wr(`PCG_IDX_CTRL, 32'hb13, 1'b1);
    wr(`PCG_IDX_CTRL, 32'ha13, 1'b0);
    repeat (4) @(posedge pclk);
    chk("auto_tuning_active", 32'h1, {31'h0, auto_on});
    apb(1'b0, `PCG_IDX_STAT, 32'h0, r, e);
    chk("auto gain", 32'd30, {21'h0, r[26:16]});
    wr(`PCG_IDX_CTRL, 32'ha03, 1'b0);
    repeat (4) @(posedge pclk);
    chk("auto_tuning_active", 32'h0, {31'h0, auto_on});
    apb(1'b0, `PCG_IDX_STAT, 32'h0, r, e);
    chk("manual gain", 32'd100, {21'h0, r[26:16]});
  endtask

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h0;
    pwdata   = 32'h0;
    inhibit  = 1'b0;
    feedback = 32'h0;
    inertia  = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ranges();
    t_gear();
    t_speed();
    t_inhibit();
    t_auto();
    complete_run();
  end
endmodule // test_position_command_gear_loop
